/* rtl/self_prog_pkg.sv */
// Shared constants and types of the flash self-programming sequencer
package self_prog_pkg;

  // ****************************************
  // Clock and operation timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;       // Core clock period
  localparam int PROG_MIN_US = 3700;       // Least duration of one flash operation
  localparam int PROG_MAX_US = 4500;       // Longest duration of one flash operation
  // Least time rounds up, longest rounds down
  localparam int PROG_MIN_CYCLES = (PROG_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYCLES = (PROG_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int TIMER_W = 17;             // Wide enough for the longest count
  localparam logic [2:0] ARM_WINDOW = 3'h4; // Cycles a command stays armed

  // ****************************************
  // Register map (byte offsets on the plain port)
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;      // self_prog_control_reg
  localparam logic [7:0] BOOT_LO_OFS = 8'h01;   // Boot section start, low byte
  localparam logic [7:0] BOOT_HI_OFS = 8'h02;   // Boot section start, high byte
  localparam logic [7:0] PAGE_OFS = 8'h03;      // Page of the running operation
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Control register field positions
  localparam int STORE_ENABLE_POS = 0;
  localparam int PAGE_ERASE_POS = 1;
  localparam int PAGE_WRITE_POS = 2;
  localparam int LOCK_SET_POS = 3;
  localparam int REENABLE_POS = 4;
  localparam int REGION_BUSY_POS = 6;

  // ****************************************
  // Flash geometry per variant
  // ****************************************
  localparam int SMALL_COUNTER_TOP = 12;   // counter_top_bit, smallest variant
  localparam int MID_COUNTER_TOP = 13;     // counter_top_bit, middle variant
  localparam int WORD_FIELD_TOP = 5;       // word_field_top_bit
  localparam logic [13:0] SMALL_CRR_TOP = 14'h1bff;
  localparam logic [13:0] MID_CRR_TOP = 14'h37ff;
  // Boot section start per fuse code 11,10,01,00
  localparam logic [13:0] SMALL_START_3 = 14'h1f80;
  localparam logic [13:0] SMALL_START_2 = 14'h1f00;
  localparam logic [13:0] SMALL_START_1 = 14'h1e00;
  localparam logic [13:0] SMALL_START_0 = 14'h1c00;
  localparam logic [13:0] MID_START_3 = 14'h3f00;
  localparam logic [13:0] MID_START_2 = 14'h3e00;
  localparam logic [13:0] MID_START_1 = 14'h3c00;
  localparam logic [13:0] MID_START_0 = 14'h3800;
  // Boot section size in words per fuse code 11,10,01,00
  localparam logic [11:0] SMALL_SIZE_3 = 12'h080;
  localparam logic [11:0] SMALL_SIZE_2 = 12'h100;
  localparam logic [11:0] SMALL_SIZE_1 = 12'h200;
  localparam logic [11:0] SMALL_SIZE_0 = 12'h400;
  localparam logic [11:0] MID_SIZE_3 = 12'h100;
  localparam logic [11:0] MID_SIZE_2 = 12'h200;
  localparam logic [11:0] MID_SIZE_1 = 12'h400;
  localparam logic [11:0] MID_SIZE_0 = 12'h800;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_BUSY = 3'b100
  } seq_state_t;

endpackage : self_prog_pkg

/* rtl/boot_map_if.sv */
// Interface carrying the boot size code and the decoded section bounds
interface boot_map_if;
  logic [1:0] size_code;     // {boot_size_sel_hi, boot_size_sel_lo}
  logic mid_variant;         // High selects the middle variant
  logic [13:0] boot_start;   // First word of the boot section
  logic [11:0] boot_words;   // Boot section size in words
  logic [13:0] app_end;      // Last word of the application section
  logic [13:0] crr_top;      // Last word of the concurrent-read region
  modport sequencer (output size_code, output mid_variant,
                     input boot_start, input boot_words, input app_end, input crr_top);
  modport decoder (input size_code, input mid_variant,
                   output boot_start, output boot_words, output app_end, output crr_top);
endinterface : boot_map_if

/* rtl/boot_map.sv */
// Boot size fuse decoder for the flash sections
module boot_map (
  boot_map_if.decoder map
);

  // ****************************************
  // Section decode
  // ****************************************

  // Pure table lookup, so the sequencer sees bounds in the same cycle
  always_comb begin
    map.boot_start = self_prog_pkg::SMALL_START_0;
    map.boot_words = self_prog_pkg::SMALL_SIZE_0;
    if (map.mid_variant) begin
      map.crr_top = self_prog_pkg::MID_CRR_TOP;
      case (map.size_code)
        2'h3: begin
          map.boot_start = self_prog_pkg::MID_START_3;
          map.boot_words = self_prog_pkg::MID_SIZE_3;
        end
        2'h2: begin
          map.boot_start = self_prog_pkg::MID_START_2;
          map.boot_words = self_prog_pkg::MID_SIZE_2;
        end
        2'h1: begin
          map.boot_start = self_prog_pkg::MID_START_1;
          map.boot_words = self_prog_pkg::MID_SIZE_1;
        end
        default: begin
          map.boot_start = self_prog_pkg::MID_START_0;
          map.boot_words = self_prog_pkg::MID_SIZE_0;
        end
      endcase
    end else begin
      map.crr_top = self_prog_pkg::SMALL_CRR_TOP;
      case (map.size_code)
        2'h3: begin
          map.boot_start = self_prog_pkg::SMALL_START_3;
          map.boot_words = self_prog_pkg::SMALL_SIZE_3;
        end
        2'h2: begin
          map.boot_start = self_prog_pkg::SMALL_START_2;
          map.boot_words = self_prog_pkg::SMALL_SIZE_2;
        end
        2'h1: begin
          map.boot_start = self_prog_pkg::SMALL_START_1;
          map.boot_words = self_prog_pkg::SMALL_SIZE_1;
        end
        default: begin
          map.boot_start = self_prog_pkg::SMALL_START_0;
          map.boot_words = self_prog_pkg::SMALL_SIZE_0;
        end
      endcase
    end
    // Application section ends just below the boot start
    map.app_end = map.boot_start - 14'h0001;
  end

endmodule : boot_map

/* rtl/flash_self_prog.sv */
// Flash self-programming sequencer: command arming, timing, region guard
// Function
// - Each timed operation lasts 3.7 to 4.5 ms
// - Smallest variant fuse code picks boot bounds
// - Middle variant fuse code picks boot bounds
// - Concurrent region ends at 0x1BFF or 0x37FF
// - Page number from pointer bits above word
// - Low word field selects buffer word
// - Pointer bit 0 selects byte on loads
// - Counter bit n sits at pointer bit n+1
// - Counter is 13 or 14 bits wide
// - Block concurrent region reads during programming
// - Busy flag set on start, cleared by re-enable
// - Command expires without store within four cycles
// - Re-enable during buffer load discards buffer
//
// Decided for this implementation: strobed register access and the register addresses.
module flash_self_prog #(
  parameter bit MID_VARIANT = 1'b0,                           // High: middle variant
  parameter int OP_CYCLES = self_prog_pkg::PROG_MIN_CYCLES    // Cycles per timed operation
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic store_exec,
  input wire logic load_exec,
  input wire logic [15:0] ptr_z,
  input wire logic [15:0] store_data,
  input wire logic eeprom_write_busy,
  input wire logic boot_size_sel_hi,
  input wire logic boot_size_sel_lo,
  output logic cpu_stall,
  output logic region_read_block,
  output logic flash_erase_start,
  output logic flash_write_start,
  output logic lock_write_start,
  output logic [7:0] flash_page,
  output logic buf_wr,
  output logic [5:0] buf_word,
  output logic [15:0] buf_wdata,
  output logic buf_clear,
  output logic load_byte_hi
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    self_prog_pkg::seq_state_t state;    // Sequencer state
    logic [1:0] fuse_meta;               // First synchroniser stage
    logic [1:0] fuse_sync;               // Second synchroniser stage
    logic store_enable_bit;              // Armed or operation in progress
    logic page_erase_cmd;
    logic page_write_cmd;
    logic lock_set_cmd;
    logic region_read_reenable_cmd;
    logic region_busy_flag;              // Concurrent region locked out
    logic loading;                       // Page buffer holds unwritten data
    logic [2:0] win;                     // Remaining cycles of the arm window
    logic [self_prog_pkg::TIMER_W-1:0] timer; // Remaining cycles of the operation
    logic stall_op;                      // Running op targets the stall region
    logic cpu_stall;
    logic erase_p;
    logic write_p;
    logic lock_p;
    logic [7:0] page;
    logic buf_wr;
    logic [5:0] word;
    logic [15:0] wdata;
    logic buf_clear;
    logic byte_hi;
    logic [7:0] rdata;
  } seq_t;

  seq_t s_reg;     // Registered state
  seq_t s_next;    // Next state

  // Decoded boot bounds
  boot_map_if map_bus ();

  boot_map u_boot_map (
    .map(map_bus)
  );

  assign map_bus.size_code = s_reg.fuse_sync;
  assign map_bus.mid_variant = MID_VARIANT;

  // ****************************************
  // Pointer decode
  // ****************************************
  localparam int COUNTER_TOP = MID_VARIANT ? self_prog_pkg::MID_COUNTER_TOP
                                           : self_prog_pkg::SMALL_COUNTER_TOP;

  logic [13:0] ptr_word_addr;   // Counter value carried in the pointer
  logic [7:0] ptr_page;         // Page number field
  logic [5:0] ptr_word;         // Word-in-page field
  logic page_in_stall;          // Addressed page lies in the stall region

  // Pointer bit 0 is the byte select, so counter bit n is pointer bit n+1
  always_comb begin
    ptr_word_addr = ptr_z[14:1];
    if (COUNTER_TOP == self_prog_pkg::SMALL_COUNTER_TOP) begin
      ptr_word_addr[13] = 1'b0;
    end
    ptr_page = {1'b0, ptr_word_addr[12:6]};
    if (MID_VARIANT) begin
      ptr_page = ptr_word_addr[13:6];
    end
    ptr_word = ptr_word_addr[self_prog_pkg::WORD_FIELD_TOP:0];
    page_in_stall = ({ptr_word_addr[13:6], 6'h00} > map_bus.crr_top);
  end

  // ****************************************
  // Sequencer next state
  // ****************************************

  // Control writes are refused while an operation runs or EEPROM is busy,
  // which protects the timed pair from a half-finished previous command
  always_comb begin
    logic ctrl_wr;
    logic take;
    ctrl_wr = 1'b0;
    take = 1'b0;
    s_next = s_reg;
    s_next.fuse_meta = {boot_size_sel_hi, boot_size_sel_lo};
    s_next.fuse_sync = s_reg.fuse_meta;
    // Strobes last one cycle
    s_next.erase_p = 1'b0;
    s_next.write_p = 1'b0;
    s_next.lock_p = 1'b0;
    s_next.buf_wr = 1'b0;
    s_next.buf_clear = 1'b0;
    ctrl_wr = reg_wr && (reg_addr == self_prog_pkg::CTRL_OFS)
              && !s_reg.store_enable_bit && !eeprom_write_busy;

    case (s_reg.state)
      self_prog_pkg::ST_IDLE: begin
        if (ctrl_wr && reg_wdata[self_prog_pkg::STORE_ENABLE_POS]) begin
          // Arm: store must follow inside the window
          s_next.store_enable_bit = 1'b1;
          s_next.page_erase_cmd = reg_wdata[self_prog_pkg::PAGE_ERASE_POS];
          s_next.page_write_cmd = reg_wdata[self_prog_pkg::PAGE_WRITE_POS];
          s_next.lock_set_cmd = reg_wdata[self_prog_pkg::LOCK_SET_POS];
          s_next.region_read_reenable_cmd = reg_wdata[self_prog_pkg::REENABLE_POS];
          s_next.win = self_prog_pkg::ARM_WINDOW;
          s_next.state = self_prog_pkg::ST_ARMED;
        end
      end
      self_prog_pkg::ST_ARMED: begin
        take = store_exec;
        s_next.win = s_reg.win - 3'h1;
        if (take) begin
          s_next.win = 3'h0;
          s_next.page = ptr_page;
          if (s_reg.page_erase_cmd || s_reg.page_write_cmd) begin
            // Timed erase or page write
            s_next.erase_p = s_reg.page_erase_cmd;
            s_next.write_p = s_reg.page_write_cmd && !s_reg.page_erase_cmd;
            s_next.timer = OP_CYCLES[self_prog_pkg::TIMER_W-1:0];
            s_next.stall_op = page_in_stall;
            s_next.cpu_stall = page_in_stall;
            if (!page_in_stall) begin
              s_next.region_busy_flag = 1'b1;
            end
            if (s_reg.page_write_cmd) begin
              s_next.loading = 1'b0;
            end
            s_next.state = self_prog_pkg::ST_BUSY;
          end else if (s_reg.lock_set_cmd) begin
            // Lock write: timed, whole flash stays readable
            s_next.lock_p = 1'b1;
            s_next.timer = OP_CYCLES[self_prog_pkg::TIMER_W-1:0];
            s_next.stall_op = 1'b0;
            s_next.state = self_prog_pkg::ST_BUSY;
          end else if (s_reg.region_read_reenable_cmd) begin
            // Re-enable; a partly filled buffer is thrown away
            s_next.region_busy_flag = 1'b0;
            s_next.buf_clear = s_reg.loading;
            s_next.loading = 1'b0;
            s_next.store_enable_bit = 1'b0;
            s_next.region_read_reenable_cmd = 1'b0;
            s_next.state = self_prog_pkg::ST_IDLE;
          end else begin
            // Plain store: one word into the page buffer
            s_next.buf_wr = 1'b1;
            s_next.word = ptr_word;
            s_next.wdata = store_data;
            s_next.loading = 1'b1;
            s_next.region_busy_flag = 1'b0;
            s_next.store_enable_bit = 1'b0;
            s_next.state = self_prog_pkg::ST_IDLE;
          end
        end else if (s_reg.win == 3'h1) begin
          // Window elapsed with no store: command auto-clears
          s_next.store_enable_bit = 1'b0;
          s_next.page_erase_cmd = 1'b0;
          s_next.page_write_cmd = 1'b0;
          s_next.lock_set_cmd = 1'b0;
          s_next.region_read_reenable_cmd = 1'b0;
          s_next.state = self_prog_pkg::ST_IDLE;
        end
      end
      self_prog_pkg::ST_BUSY: begin
        // Store enable stays high until the counter runs out
        s_next.timer = s_reg.timer - 1'b1;
        if (s_reg.timer == {{(self_prog_pkg::TIMER_W-1){1'b0}}, 1'b1}) begin
          s_next.store_enable_bit = 1'b0;
          s_next.page_erase_cmd = 1'b0;
          s_next.page_write_cmd = 1'b0;
          s_next.lock_set_cmd = 1'b0;
          s_next.region_read_reenable_cmd = 1'b0;
          s_next.cpu_stall = 1'b0;
          s_next.stall_op = 1'b0;
          s_next.state = self_prog_pkg::ST_IDLE;
        end
      end
      default: begin
        s_next.state = self_prog_pkg::ST_IDLE;
      end
    endcase

    // Loads latch the byte select of the pointer
    if (load_exec) begin
      s_next.byte_hi = ptr_z[0];
    end

    // Read data stands in the cycle after the strobe, zero otherwise
    s_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        self_prog_pkg::CTRL_OFS: begin
          s_next.rdata[self_prog_pkg::STORE_ENABLE_POS] = s_reg.store_enable_bit;
          s_next.rdata[self_prog_pkg::PAGE_ERASE_POS] = s_reg.page_erase_cmd;
          s_next.rdata[self_prog_pkg::PAGE_WRITE_POS] = s_reg.page_write_cmd;
          s_next.rdata[self_prog_pkg::LOCK_SET_POS] = s_reg.lock_set_cmd;
          s_next.rdata[self_prog_pkg::REENABLE_POS] = s_reg.region_read_reenable_cmd;
          s_next.rdata[self_prog_pkg::REGION_BUSY_POS] = s_reg.region_busy_flag;
        end
        self_prog_pkg::BOOT_LO_OFS: begin
          s_next.rdata = map_bus.boot_start[7:0];
        end
        self_prog_pkg::BOOT_HI_OFS: begin
          s_next.rdata = {2'h0, map_bus.boot_start[13:8]};
        end
        self_prog_pkg::PAGE_OFS: begin
          s_next.rdata = s_reg.page;
        end
        default: begin
          s_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************

  // Clock enable low freezes every bit, strobes included
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.state <= self_prog_pkg::ST_IDLE;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs, each straight from a flip-flop
  // ****************************************
  assign reg_rdata = s_reg.rdata;
  assign cpu_stall = s_reg.cpu_stall;
  assign region_read_block = s_reg.region_busy_flag;
  assign flash_erase_start = s_reg.erase_p;
  assign flash_write_start = s_reg.write_p;
  assign lock_write_start = s_reg.lock_p;
  assign flash_page = s_reg.page;
  assign buf_wr = s_reg.buf_wr;
  assign buf_word = s_reg.word;
  assign buf_wdata = s_reg.wdata;
  assign buf_clear = s_reg.buf_clear;
  assign load_byte_hi = s_reg.byte_hi;

endmodule : flash_self_prog

/* testbench/flash_self_prog_asserts.sv */
// Port-level checker for the flash self-programming sequencer
module flash_self_prog_asserts #(
  parameter bit MID_VARIANT = 1'b0,
  parameter int OP_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic store_exec,
  input wire logic load_exec,
  input wire logic [15:0] ptr_z,
  input wire logic [15:0] store_data,
  input wire logic cpu_stall,
  input wire logic region_read_block,
  input wire logic flash_erase_start,
  input wire logic flash_write_start,
  input wire logic [7:0] flash_page,
  input wire logic buf_wr,
  input wire logic [5:0] buf_word,
  input wire logic [15:0] buf_wdata,
  input wire logic load_byte_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Helper logic
  // ****************************************
  logic [7:0] exp_page; // Page field taken from the pointer bits above the word field
  logic [16:0] stall_cnt_reg; // Cycles of the current stall
  logic [16:0] stall_cnt_next;
  assign exp_page = MID_VARIANT ? ptr_z[14:7] : {1'b0, ptr_z[13:7]};

  // Counts only enabled cycles, since a frozen block may stall longer in wall time
  always_comb begin
    stall_cnt_next = stall_cnt_reg;
    if (!cpu_stall) begin
      stall_cnt_next = 17'h00000;
    end else if (clk_en) begin
      stall_cnt_next = stall_cnt_reg + 17'h00001;
    end
  end

  // Stall length register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_reg <= 17'h00000;
    end else begin
      stall_cnt_reg <= stall_cnt_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  start_cause_a: assert property ((flash_erase_start || flash_write_start) |-> $past(store_exec))
    else $error("operation started without a store");
  start_once_a: assert property (flash_erase_start |=> !flash_erase_start [*3])
    else $error("erase start repeated during the operation");
  page_field_a: assert property ((flash_erase_start || flash_write_start) |->
    flash_page == $past(exp_page)) else $error("page number not from pointer");
  buf_word_a: assert property (buf_wr |-> buf_word == $past(ptr_z[6:1])
    && buf_wdata == $past(store_data)) else $error("buffer word or data wrong");
  busy_clear_a: assert property (buf_wr |-> !region_read_block)
    else $error("busy flag kept over a buffer load");
  busy_rise_a: assert property ($rose(region_read_block) |->
    (flash_erase_start || flash_write_start)) else $error("busy flag rose without an operation");
  stall_rise_a: assert property ($rose(cpu_stall) |->
    (flash_erase_start || flash_write_start) ##1 cpu_stall [*7]) else $error("stall start wrong");
  stall_len_a: assert property (stall_cnt_reg <= OP_CYCLES)
    else $error("stall longer than the operation");
  byte_sel_a: assert property ($past(load_exec && clk_en) |->
    load_byte_hi == $past(ptr_z[0])) else $error("byte select not taken from pointer");
endmodule : flash_self_prog_asserts

/* testbench/core_model.sv */
// Processor core model running boot loader store and load sequences
module core_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic eeprom_write_busy,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic store_exec,
  output logic load_exec,
  output logic [15:0] ptr_z,
  output logic [15:0] store_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, store_exec, load_exec} = 20'h00000;
    ptr_z = 16'h0000;
    store_data = 16'h0000;
  end

  // One-cycle register write; the released address shows junk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
  endtask : wr

  // One-cycle register read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd

  // Timed control write and store; gap delays the store
  task automatic spm(input logic [7:0] cmd, input logic [15:0] z, input logic [15:0] dat,
                     input int gap);
    logic [7:0] s;
    s = 8'h01;
    while (s[0]) rd(8'h00, s);
    while (eeprom_write_busy) @(posedge ref_clk);
    wr(8'h00, cmd);
    repeat (gap) @(posedge ref_clk);
    ptr_z <= z;
    store_data <= dat;
    store_exec <= 1'b1;
    @(posedge ref_clk);
    store_exec <= 1'b0;
    ptr_z <= ~z;
    store_data <= ~dat;
  endtask : spm

  // Load from program memory at pointer z
  task automatic ld(input logic [15:0] z);
    @(posedge ref_clk);
    ptr_z <= z;
    load_exec <= 1'b1;
    @(posedge ref_clk);
    load_exec <= 1'b0;
    ptr_z <= ~z;
  endtask : ld

  // Full page update of two words, then wait until the region is readable
  task automatic page_update(input logic [15:0] z);
    logic [7:0] s;
    spm(8'h03, z, 16'h0000, 0);
    spm(8'h11, z, 16'h0000, 0);
    spm(8'h01, z, 16'h1234, 0);
    spm(8'h01, z + 16'h0002, 16'h5678, 0);
    spm(8'h05, z, 16'h0000, 0);
    s = 8'h40;
    while (s[6]) begin
      spm(8'h11, z, 16'h0000, 0);
      rd(8'h00, s);
    end
  endtask : page_update
endmodule : core_model

/* testbench/flash_self_prog_bench.sv */
// Self-checking bench for the flash self-programming sequencer
module flash_self_prog_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OPS = 20; // Shortened operation length
  logic ref_clk, rst_n, clk_en, ee_busy, hi, lo, reg_wr, reg_rd, store_exec, load_exec;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, flash_page;
  logic [15:0] ptr_z, store_data, buf_wdata;
  logic cpu_stall, region_read_block, erase_s, write_s, lock_s, buf_wr, buf_clear, byte_hi;
  logic [5:0] buf_word;
  logic [7:0] d, h;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0;

  flash_self_prog #(.MID_VARIANT(1'b0), .OP_CYCLES(OPS)) dut_u (.ref_clk(ref_clk),
    .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_exec(store_exec),
    .load_exec(load_exec), .ptr_z(ptr_z), .store_data(store_data),
    .eeprom_write_busy(ee_busy), .boot_size_sel_hi(hi), .boot_size_sel_lo(lo),
    .cpu_stall(cpu_stall), .region_read_block(region_read_block), .flash_erase_start(erase_s),
    .flash_write_start(write_s), .lock_write_start(lock_s), .flash_page(flash_page),
    .buf_wr(buf_wr), .buf_word(buf_word), .buf_wdata(buf_wdata), .buf_clear(buf_clear),
    .load_byte_hi(byte_hi));
  core_model core_u (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .eeprom_write_busy(ee_busy),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .store_exec(store_exec), .load_exec(load_exec), .ptr_z(ptr_z), .store_data(store_data));

  // Clock at 25 MHz and a cycle count for timing checks
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc++;

  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // Boot start for each fuse code, plus an unmapped read
  task automatic t_boot();
    logic [13:0] st [4] = '{14'h1c00, 14'h1e00, 14'h1f00, 14'h1f80};
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {hi, lo} <= 2'(i);
      repeat (4) @(posedge ref_clk);
      core_u.rd(8'h01, d);
      core_u.rd(8'h02, h);
      chk("boot_start", 16'(st[i]), {h, d});
    end
    core_u.rd(8'h07, d);
    chk("unmapped", 16'h0000, 16'(d));
  endtask : t_boot

  // Timed operation: pulse, page, busy, stall, duration, then re-enable
  task automatic t_op(input logic [7:0] cmd, input logic [15:0] z, input logic [7:0] pg,
                      input logic busy, input logic stall);
    core_u.spm(cmd, z, 16'h0000, 0);
    t0 = cyc;
    #1 chk("starts", 16'(cmd[3:1]), 16'({lock_s, write_s, erase_s}));
    if (cmd[3:1] != 3'h4) chk("page", 16'(pg), 16'(flash_page));
    chk("busy", 16'(busy), 16'(region_read_block));
    chk("stall", 16'(stall), 16'(cpu_stall));
    d = 8'h01;
    while (d[0]) core_u.rd(8'h00, d);
    chk("op_long", 16'h0001, 16'(cyc - t0 >= OPS - 2 && cyc - t0 <= OPS + 4));
    chk("stall_end", 16'h0000, 16'(cpu_stall));
    core_u.spm(8'h11, z, 16'h0000, 0);
    #1 chk("reenable", 16'h0000, 16'(region_read_block));
  endtask : t_op

  // Buffer load clears busy; re-enable during loading discards the buffer
  task automatic t_buf();
    core_u.spm(8'h03, 16'h0080, 16'h0000, 0);
    core_u.spm(8'h01, 16'h000a, 16'hbeef, 0);
    #1 chk("buf_wr", 16'h0001, 16'(buf_wr));
    chk("buf_word", 16'h0005, 16'(buf_word));
    chk("buf_wdata", 16'hbeef, buf_wdata);
    chk("busy_load", 16'h0000, 16'(region_read_block));
    core_u.spm(8'h11, 16'h0000, 16'h0000, 0);
    #1 chk("buf_clear", 16'h0001, 16'(buf_clear));
  endtask : t_buf

  // Store late by one cycle is dropped; store on the last armed cycle works
  task automatic t_window();
    core_u.spm(8'h03, 16'h0100, 16'h0000, 4);
    #1 chk("late_erase", 16'h0000, 16'(erase_s));
    core_u.rd(8'h00, d);
    chk("ctrl_clear", 16'h0000, 16'(d));
    core_u.spm(8'h01, 16'h0004, 16'h00a5, 3);
    #1 chk("edge_load", 16'h0001, 16'(buf_wr));
  endtask : t_window

  // Control writes refused while an EEPROM write runs; byte select on loads
  task automatic t_misc();
    @(posedge ref_clk);
    ee_busy <= 1'b1;
    core_u.wr(8'h00, 8'h03);
    core_u.rd(8'h00, d);
    chk("ee_refuse", 16'h0000, 16'(d));
    ee_busy <= 1'b0;
    core_u.ld(16'h0003);
    #1 chk("byte_hi", 16'h0001, 16'(byte_hi));
    core_u.ld(16'h0002);
    #1 chk("byte_lo", 16'h0000, 16'(byte_hi));
  endtask : t_misc

  // Verdict and end of run
  task automatic complete_run();
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Watchdog well beyond the run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    {rst_n, clk_en, ee_busy, hi, lo} = 5'h00;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    clk_en <= 1'b1;
    core_u.rd(8'h00, d);
    chk("ctrl_reset", 16'h0000, 16'(d));
    chk("min_time", 16'h0001, 16'(self_prog_pkg::PROG_MIN_CYCLES * 40 >= 3700000));
    chk("max_time", 16'h0001, 16'(self_prog_pkg::PROG_MAX_CYCLES * 40 <= 4500000));
    t_boot();
    t_op(8'h03, 16'h3780, 8'h6f, 1'b1, 1'b0);
    t_op(8'h03, 16'h3800, 8'h70, 1'b0, 1'b1);
    t_op(8'h05, 16'h0100, 8'h02, 1'b1, 1'b0);
    t_op(8'h09, 16'h0000, 8'h00, 1'b0, 1'b0);
    t_buf();
    t_window();
    t_misc();
    core_u.page_update(16'h0200);
    chk("update_done", 16'h0000, 16'(region_read_block));
    complete_run();
  end
endmodule : flash_self_prog_bench

bind flash_self_prog flash_self_prog_asserts #(.MID_VARIANT(MID_VARIANT),
  .OP_CYCLES(OP_CYCLES)) chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
  .store_exec(store_exec), .load_exec(load_exec), .ptr_z(ptr_z), .store_data(store_data),
  .cpu_stall(cpu_stall), .region_read_block(region_read_block),
  .flash_erase_start(flash_erase_start), .flash_write_start(flash_write_start),
  .flash_page(flash_page), .buf_wr(buf_wr), .buf_word(buf_word), .buf_wdata(buf_wdata),
  .load_byte_hi(load_byte_hi));
